// ==== core/acr_pkg.sv ====
/*
  Types shared by the converter control register bank.
  Includes no header; only the core module includes the constants header.
*/
package acr_pkg;
  typedef logic [7:0] acr_byte_t;
  typedef logic [15:0] acr_word_t;
  typedef logic [9:0] acr_pace_t;
endpackage

// ==== core/acr_regs.svh ====
/*
  Register offsets, field positions and reset values of the converter
  control register bank.
  Assumes inclusion by bare name from the core module.
*/
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

`define ACR_ADDR_STANDBY 7'h00
`define ACR_ADDR_MODE_A 7'h01
`define ACR_ADDR_MODE_B 7'h02
`define ACR_ADDR_MODE_SEL 7'h03
`define ACR_ADDR_POWER 7'h04
`define ACR_ADDR_GAP 7'h05
`define ACR_ADDR_DATA_CTL 7'h06
`define ACR_ADDR_IFACE 7'h07
`define ACR_ADDR_ANA_PRE 7'h08
`define ACR_ADDR_REF_PRE 7'h09
`define ACR_ADDR_CAL_FIRST 7'h0a
`define ACR_ADDR_LAST_RW 7'h21
`define ACR_ADDR_STATUS 7'h22

`define ACR_BIT_FILTER 3
`define ACR_BIT_SLEEP 7
`define ACR_BIT_SYNC 7
`define ACR_BIT_SINGLE 4
`define ACR_BIT_CRC 3
`define ACR_BIT_HEADER 4
`define ACR_DATA_CTL_MASK 8'h90

`define ACR_RST_STANDBY 8'h00
`define ACR_RST_MODE 8'h0d
`define ACR_RST_MODE_SEL 8'h00
`define ACR_RST_POWER 8'h00
`define ACR_RST_DATA_CTL 8'h80
`define ACR_RST_IFACE 8'h13
`define ACR_RST_ANA_PRE 8'hff
`define ACR_RST_REF_PRE 8'h00
`define ACR_RST_CAL 8'h00

`define ACR_SRST_ARM 2'h3
`define ACR_SRST_FIRE 2'h2
`define ACR_ERROR_WORD 16'h0e00
`define ACR_FRAME_BITS 5'd16
`define ACR_DEC_MAX 3'h5
`define ACR_MASK_FULL 10'h3ff

`endif

// ==== core/acr_spi_regs.sv ====
/*
  Control register bank of a multichannel sampling converter, reached
  over a 16-bit SPI mode 0 slave, with output pacing and sleep control.
  Assumes SCLK is at most one eighth of clock, and that modTick is a
  one-cycle modulator-rate enable made by logic on clock.
*/
`timescale 1ns/1ps
`include "acr_regs.svh"

module acr_spi_regs #(
  parameter int NUM_CH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdi,
  input wire logic modTick,
  output logic sdo,
  output logic sdoOe,
  output logic drdy,
  output logic [NUM_CH-1:0] repeatFlags,
  output logic [NUM_CH-1:0] channelDataEn,
  output logic [NUM_CH-1:0] filterSinc,
  output logic [NUM_CH-1:0] anaPrecharge,
  output logic [NUM_CH-1:0] refPrecharge,
  output logic [1:0] powerMode,
  output logic [1:0] mclkDivCode,
  output logic [1:0] dataClockDiv,
  output logic headerEn,
  output logic crcEn,
  output logic singleShot,
  output logic sleepMode,
  output logic syncOut
);

  localparam int NUM_RW = 34;
  localparam logic [7:0] CH_MASK = 8'((9'h001 << NUM_CH) - 9'h001);

  // Stage [0] is the first synchroniser flop; only stage [1] reads it.
  logic [2:0] sclkSync;
  logic [2:0] csSync;
  logic [1:0] sdiSync;
  logic [4:0] bitCnt;
  acr_pkg::acr_word_t shiftIn;
  acr_pkg::acr_word_t shiftOut;
  acr_pkg::acr_word_t respReg;
  acr_pkg::acr_byte_t regMem [NUM_RW];
  logic resetArmed;
  logic ackPending;
  acr_pkg::acr_pace_t paceCnt;

  function automatic logic writable(input logic [6:0] a);
    writable = (a <= `ACR_ADDR_LAST_RW) && (a != `ACR_ADDR_GAP);
  endfunction

  function automatic acr_pkg::acr_byte_t resetValue(input int i);
    if (i >= int'(`ACR_ADDR_CAL_FIRST)) begin
      resetValue = `ACR_RST_CAL;
    end else begin
      unique case (7'(i))
        `ACR_ADDR_STANDBY: resetValue = `ACR_RST_STANDBY;
        `ACR_ADDR_MODE_A: resetValue = `ACR_RST_MODE;
        `ACR_ADDR_MODE_B: resetValue = `ACR_RST_MODE;
        `ACR_ADDR_MODE_SEL: resetValue = `ACR_RST_MODE_SEL;
        `ACR_ADDR_POWER: resetValue = `ACR_RST_POWER;
        `ACR_ADDR_DATA_CTL: resetValue = `ACR_RST_DATA_CTL;
        `ACR_ADDR_IFACE: resetValue = `ACR_RST_IFACE;
        `ACR_ADDR_ANA_PRE: resetValue = `ACR_RST_ANA_PRE;
        `ACR_ADDR_REF_PRE: resetValue = `ACR_RST_REF_PRE;
        default: resetValue = 8'h00;
      endcase
    end
  endfunction

  // Decimation 32 << code, so the low bits of the pace counter that must
  // be zero form a mask; codes above the largest ratio are clamped.
  function automatic acr_pkg::acr_pace_t ratioMask(input logic [2:0] code);
    logic [2:0] c;
    c = (code > `ACR_DEC_MAX) ? `ACR_DEC_MAX : code;
    ratioMask = `ACR_MASK_FULL >> (`ACR_DEC_MAX - c);
  endfunction

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclkSync <= 3'h0;
      csSync <= 3'h7;
      sdiSync <= 2'h0;
    end else begin
      sclkSync <= {sclkSync[1:0], sclk};
      csSync <= {csSync[1:0], csN};
      sdiSync <= {sdiSync[0], sdi};
    end
  end

  logic sclkRise;
  logic sclkFall;
  logic csFall;
  logic csRise;
  logic frameDone;
  logic cmdRead;
  logic [6:0] cmdAddr;
  acr_pkg::acr_byte_t cmdData;
  logic cmdIllegal;
  logic cmdWrite;
  logic softReset;
  logic syncPulse;
  acr_pkg::acr_byte_t readData;
  acr_pkg::acr_byte_t statusByte;

  assign sclkRise = sclkSync[1] & ~sclkSync[2];
  assign sclkFall = ~sclkSync[1] & sclkSync[2];
  assign csFall = ~csSync[1] & csSync[2];
  assign csRise = csSync[1] & ~csSync[2];
  // Short or long frames are dropped without touching the registers or the response.
  assign frameDone = csRise && (bitCnt == `ACR_FRAME_BITS);
  assign cmdRead = shiftIn[15];
  assign cmdAddr = shiftIn[14:8];
  assign cmdData = shiftIn[7:0];
  assign cmdIllegal = cmdRead
    ? !(writable(cmdAddr) || cmdAddr == `ACR_ADDR_STATUS)
    : !writable(cmdAddr);
  assign cmdWrite = frameDone && !cmdRead && !cmdIllegal;
  assign softReset = cmdWrite && cmdAddr == `ACR_ADDR_DATA_CTL && resetArmed
    && cmdData[1:0] == `ACR_SRST_FIRE;
  assign syncPulse = cmdWrite && cmdAddr == `ACR_ADDR_DATA_CTL
    && cmdData[`ACR_BIT_SYNC] && !regMem[6][`ACR_BIT_SYNC];
  assign statusByte = {regMem[4][`ACR_BIT_SLEEP], regMem[6][`ACR_BIT_SYNC],
    5'h00, ackPending};

  always_comb begin
    if (cmdAddr == `ACR_ADDR_STATUS) begin
      readData = statusByte;
    end else if (writable(cmdAddr)) begin
      readData = regMem[cmdAddr[5:0]];
    end else begin
      readData = 8'h00;
    end
  end

  // Serial shifter: sample on SCLK rise, drive on SCLK fall.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bitCnt <= 5'd0;
      shiftIn <= 16'h0000;
      shiftOut <= 16'h0000;
      sdo <= 1'b0;
      sdoOe <= 1'b0;
    end else if (csFall) begin
      bitCnt <= 5'd0;
      sdo <= respReg[15];
      shiftOut <= {respReg[14:0], 1'b0};
      sdoOe <= 1'b1;
    end else if (!csSync[1]) begin
      if (sclkRise) begin
        shiftIn <= {shiftIn[14:0], sdiSync[1]};
        if (bitCnt != `ACR_FRAME_BITS + 5'd1) begin
          bitCnt <= bitCnt + 5'd1;
        end
      end
      if (sclkFall) begin
        sdo <= shiftOut[15];
        shiftOut <= {shiftOut[14:0], 1'b0};
      end
    end else begin
      sdoOe <= 1'b0;
      sdo <= 1'b0;
    end
  end

  // The answer to one frame is shifted out during the next.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      respReg <= 16'h0000;
    end else if (frameDone) begin
      if (ackPending || cmdIllegal) begin
        respReg <= `ACR_ERROR_WORD;
      end else if (cmdRead) begin
        respReg <= {8'h00, readData};
      end else begin
        respReg <= {8'h00, cmdData};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || softReset) begin
      resetArmed <= 1'b0;
    end else if (frameDone) begin
      resetArmed <= cmdWrite && cmdAddr == `ACR_ADDR_DATA_CTL
        && cmdData[1:0] == `ACR_SRST_ARM;
    end
  end

  // A soft reset that lands with a frame end wins over the clear.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ackPending <= 1'b0;
    end else if (softReset) begin
      ackPending <= 1'b1;
    end else if (frameDone) begin
      ackPending <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || softReset) begin
      for (int i = 0; i < NUM_RW; i++) begin
        regMem[i] <= resetValue(i);
      end
    end else if (cmdWrite) begin
      unique case (cmdAddr)
        // Input precharge enables are written inverted.
        `ACR_ADDR_ANA_PRE: regMem[cmdAddr[5:0]] <= ~cmdData;
        // Reset codes are commands, not settings, and are not kept.
        `ACR_ADDR_DATA_CTL: regMem[cmdAddr[5:0]] <= cmdData & `ACR_DATA_CTL_MASK;
        // Bit 7 written to zero here is how sleep is left.
        `ACR_ADDR_POWER: regMem[cmdAddr[5:0]] <= cmdData;
        default: regMem[cmdAddr[5:0]] <= cmdData;
      endcase
    end
  end

  logic [7:0] modeSel;
  logic [7:0] standby;
  logic usedA;
  logic usedB;
  logic allOnB;
  logic sleeping;
  acr_pkg::acr_pace_t maskA;
  acr_pkg::acr_pace_t maskB;
  acr_pkg::acr_pace_t fastMask;
  acr_pkg::acr_pace_t nextCnt;

  assign modeSel = regMem[3] & CH_MASK;
  assign standby = regMem[0] & CH_MASK;
  assign usedA = |(~modeSel & CH_MASK);
  assign usedB = |modeSel;
  assign allOnB = (NUM_CH == 8) && (modeSel == CH_MASK);
  assign sleeping = regMem[4][`ACR_BIT_SLEEP];
  assign maskA = ratioMask(regMem[1][2:0]);
  assign maskB = ratioMask(regMem[2][2:0]);
  // Ratios are powers of two, so the faster mode's mask is the AND.
  assign fastMask = (usedA && usedB) ? (maskA & maskB)
    : (usedB ? maskB : maskA);
  assign nextCnt = paceCnt + 10'd1;

  // A serial sync restarts the decimation phase of every channel.
  always_ff @(posedge clock) begin
    if (!rst_n || softReset || syncPulse) begin
      paceCnt <= 10'd0;
    end else if (modTick && !sleeping) begin
      paceCnt <= nextCnt;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      drdy <= 1'b0;
    end else begin
      drdy <= modTick && !sleeping && !allOnB && !syncPulse
        && ((nextCnt & fastMask) == 10'd0);
    end
  end

  // Flags are refreshed at every pacing point, also where drdy is held off by a sync or by all channels on mode B.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      repeatFlags <= '0;
    end else if (modTick && !sleeping && ((nextCnt & fastMask) == 10'd0)) begin
      for (int i = 0; i < NUM_CH; i++) begin
        repeatFlags[i] <= (nextCnt & (modeSel[i] ? maskB : maskA)) != 10'd0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      channelDataEn <= '0;
      filterSinc <= '0;
      anaPrecharge <= '0;
      refPrecharge <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        channelDataEn[i] <= !standby[i] && !sleeping && !allOnB;
        filterSinc[i] <= modeSel[i] ? regMem[2][`ACR_BIT_FILTER]
          : regMem[1][`ACR_BIT_FILTER];
        anaPrecharge[i] <= regMem[8][i];
        refPrecharge[i] <= regMem[9][i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      powerMode <= 2'h0;
      mclkDivCode <= 2'h0;
      dataClockDiv <= 2'h0;
      headerEn <= 1'b0;
      crcEn <= 1'b0;
      singleShot <= 1'b0;
      sleepMode <= 1'b0;
      syncOut <= 1'b1;
    end else begin
      powerMode <= regMem[4][5:4];
      mclkDivCode <= regMem[4][1:0];
      dataClockDiv <= regMem[7][1:0];
      headerEn <= regMem[7][`ACR_BIT_HEADER];
      crcEn <= regMem[7][`ACR_BIT_CRC];
      singleShot <= regMem[6][`ACR_BIT_SINGLE];
      sleepMode <= sleeping;
      syncOut <= regMem[6][`ACR_BIT_SYNC];
    end
  end

endmodule

// ==== dv/acr_host_model.sv ====
/*
  Host model: SPI mode 0 master for the register bank.
  Assumes clock is the design clock; the bench calls xfer.
*/
`timescale 1ns/1ps
module acr_host_model (
  input wire logic clock,
  output logic sclk,
  output logic csN,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    sdi = 1'b0;
  end

  // Sixteen bits MSB first, four clocks per half period.
  task automatic xfer(input acr_pkg::acr_word_t cmd, output acr_pkg::acr_word_t rsp);
    @(negedge clock);
    csN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = cmd[i];
      repeat (4) @(negedge clock);
      sclk = 1'b1;
      rsp[i] = sdo;
      repeat (4) @(negedge clock);
      sclk = 1'b0;
    end
    repeat (4) @(negedge clock);
    csN = 1'b1;
    // A released line must not keep looking like valid data.
    sdi = ~sdi;
    repeat (8) @(negedge clock);
  endtask
endmodule

// ==== dv/acr_spi_regs_chk.sv ====
/*
  Port checker for the register bank.
  Assumes it is bound to acr_spi_regs; one clock domain.
*/
`timescale 1ns/1ps
module acr_spi_regs_chk #(
  parameter int NUM_CH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic modTick,
  input wire logic sdo,
  input wire logic sdoOe,
  input wire logic drdy,
  input wire logic [NUM_CH-1:0] channelDataEn,
  input wire logic [NUM_CH-1:0] filterSinc,
  input wire logic [NUM_CH-1:0] anaPrecharge,
  input wire logic [NUM_CH-1:0] refPrecharge,
  input wire logic [1:0] powerMode,
  input wire logic [1:0] mclkDivCode,
  input wire logic [1:0] dataClockDiv,
  input wire logic headerEn,
  input wire logic crcEn,
  input wire logic sleepMode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence defaults_s;
    ##2 (powerMode == 2'h0 && mclkDivCode == 2'h0 && dataClockDiv == 2'h3);
  endsequence
  sequence quiet_s;
    !drdy [*8];
  endsequence

  rst_cfg_a: assert property (
    $rose(rst_n) |-> defaults_s ##0 (headerEn && !crcEn)) else $error("reset config wrong");
  rst_chan_a: assert property (
    $rose(rst_n) |-> ##2 (filterSinc == '1 && anaPrecharge == '1 && refPrecharge == '0))
    else $error("reset channel config wrong");
  frame_open_a: assert property (
    $fell(csN) |-> ##[2:5] sdoOe) else $error("sdo not enabled in frame");
  frame_close_a: assert property (
    $rose(csN) |-> ##[2:5] !sdoOe) else $error("sdo enable stuck after frame");
  sdo_hold_a: assert property (
    $changed(sdo) && sdoOe && $past(sdoOe) |-> !sclk) else $error("sdo moved while sclk high");
  drdy_gap_a: assert property (
    drdy |=> quiet_s) else $error("data ready too frequent");
  drdy_tick_a: assert property (
    drdy |-> $past(modTick)) else $error("data ready without tick");
  sleep_hush_a: assert property (
    sleepMode && $past(sleepMode, 2) |-> !drdy && channelDataEn == '0)
    else $error("activity during sleep");
endmodule

bind acr_spi_regs acr_spi_regs_chk #(.NUM_CH(NUM_CH)) chk (.clock(clock), .rst_n(rst_n),
  .sclk(sclk), .csN(csN), .modTick(modTick), .sdo(sdo), .sdoOe(sdoOe), .drdy(drdy),
  .channelDataEn(channelDataEn), .filterSinc(filterSinc), .anaPrecharge(anaPrecharge),
  .refPrecharge(refPrecharge), .powerMode(powerMode), .mclkDivCode(mclkDivCode),
  .dataClockDiv(dataClockDiv), .headerEn(headerEn), .crcEn(crcEn), .sleepMode(sleepMode));

// ==== dv/tb.sv ====
/*
  Self-checking bench for the register bank.
  Assumes the host model and the bound checker.
*/
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic modTick = 1'b0;
  logic tickOn = 1'b0;
  logic sclk, csN, sdi, sdo, sdoOe, drdy, hdr, crc, sgl, slp, syn;
  logic [7:0] rpt, chEn, fs, ap, rp;
  logic [1:0] pm, md, dc;
  logic [7:0] f [3];
  int g [3];
  int n;
  int mismatches = 0;
  int tests_run = 0;

  acr_spi_regs dut (.clock(clock), .rst_n(rst_n), .sclk(sclk), .csN(csN), .sdi(sdi),
    .modTick(modTick), .sdo(sdo), .sdoOe(sdoOe), .drdy(drdy), .repeatFlags(rpt),
    .channelDataEn(chEn), .filterSinc(fs), .anaPrecharge(ap), .refPrecharge(rp),
    .powerMode(pm), .mclkDivCode(md), .dataClockDiv(dc), .headerEn(hdr), .crcEn(crc),
    .singleShot(sgl), .sleepMode(slp), .syncOut(syn));
  acr_host_model host (.clock(clock), .sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo));

  always #10 clock = ~clock;
  always @(negedge clock) modTick <= tickOn & ~modTick;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Each frame returns the answer to the frame before it.
  task automatic cmd(input logic [15:0] c, input logic [15:0] e);
    acr_pkg::acr_word_t r;
    host.xfer(c, r);
    chk(r, e);
  endtask

  task automatic end_of_test();
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clock);
    mismatches++;
    end_of_test();
  end

  initial begin
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    // Ticks run from here on so that sleep has pacing to stop.
    tickOn = 1'b1;
    repeat (10) @(negedge clock);
    cmd(16'h8100, 16'h0000);
    cmd(16'h8200, 16'h000d);
    cmd(16'h8300, 16'h000d);
    cmd(16'h8400, 16'h0000);
    cmd(16'h8700, 16'h0000);
    cmd(16'h8800, 16'h0013);
    cmd(16'h8900, 16'h00ff);
    cmd(16'h8a00, 16'h0000);
    cmd(16'h8600, 16'h0000);
    chk({8'h00, sgl, hdr, crc, 5'h00}, 16'h0040);
    $display("defaults test done");
    cmd(16'h000f, 16'h0080);
    chk(16'(chEn), 16'h00f0);
    cmd(16'h0102, 16'h000f);
    cmd(16'h0380, 16'h0002);
    chk(16'(fs), 16'h0080);
    cmd(16'h2200, 16'h0080);
    cmd(16'hc000, 16'h0e00);
    cmd(16'h0511, 16'h0e00);
    cmd(16'h8100, 16'h0e00);
    cmd(16'h0480, 16'h0002);
    chk({7'h00, slp, chEn}, 16'h0100);
    cmd(16'h0400, 16'h0080);
    chk({7'h00, slp, chEn}, 16'h00f0);
    cmd(16'h0801, 16'h0000);
    chk(16'(ap), 16'h00fe);
    cmd(16'h8800, 16'h0001);
    $display("access test done");
    cmd(16'h0683, 16'h00fe);
    cmd(16'h0682, 16'h0083);
    cmd(16'h8300, 16'h0082);
    chk(16'(ap), 16'h00ff);
    cmd(16'h8000, 16'h0e00);
    cmd(16'h8100, 16'h0000);
    cmd(16'h0108, 16'h000d);
    cmd(16'h0209, 16'h0008);
    cmd(16'h0301, 16'h0009);
    cmd(16'h0600, 16'h0001);
    chk(16'(syn), 16'h0000);
    cmd(16'h0680, 16'h0000);
    chk(16'(syn), 16'h0001);
    $display("soft reset test done");
    tickOn = 1'b1;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(negedge clock);
        n++;
      end while (drdy !== 1'b1 && n < 500);
      g[k] = n;
      f[k] = rpt;
    end
    chk(16'(g[1]), 16'd64);
    chk(16'(g[2]), 16'd64);
    chk(16'(f[1] ^ f[2]), 16'h0001);
    chk(16'(f[1] | f[2]), 16'h0001);
    cmd(16'h03ff, 16'h0080);
    chk(16'(chEn), 16'h0000);
    n = 0;
    repeat (300) begin
      @(negedge clock);
      n += int'(drdy === 1'b1);
    end
    chk(16'(n), 16'h0000);
    $display("pacing test done");
    end_of_test();
  end
endmodule
